// [rtl/lutr_top.sv]
`timescale 1ns/1ps
`include "lutr_cfg.svh"

module lutr_top
    import lutr_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        ce_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [3:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        wclk_i,
    input  wire lutr_wport_s wport_i,
    input  wire logic [3:0]  secondary_read_addr_i,
    output logic             primary_read_out_o,
    output logic             secondary_read_out_o
);

    // ************************************************
    // state and decode
    // ************************************************

    lutr_top_s   s_q;
    lutr_top_s   s_d;

    logic        mode_dp;
    logic        mode_32;
    logic        lvl_eff;
    logic        edge_ev;
    logic        wr_go;
    logic        bus_req;
    logic        bus_wr;
    logic        glitch_set;
    logic        glitch_clr;
    logic        prim_d;
    logic        sec_d;
    logic [4:0]  a5;
    logic [31:0] mem32;

    logic [`LUTR_FG_CNT-1:0]        fg_we;
    logic [`LUTR_FG_CNT-1:0]        fg_wd;
    logic [`LUTR_FG_CNT-1:0]        fg_rd;
    logic [`LUTR_FG_CNT-1:0][3:0]   fg_ra;
    logic [`LUTR_FG_CNT-1:0][15:0]  fg_bits;

    assign mode_dp = (s_q.ctrl.mode == `LUTR_MODE_DP16X1);
    assign mode_32 = (s_q.ctrl.mode == `LUTR_MODE_SP32X1);

    // dual-port ignores the level bit
    assign lvl_eff = s_q.ctrl.lvl && !mode_dp; // see RL4

    // write clock is sampled, its edge found against last cycle
    assign edge_ev = s_q.ctrl.fall ? (s_q.wclk_prev && !wclk_i)
                                   : (!s_q.wclk_prev && wclk_i); // see RL20

    // reset blocks writes so contents survive it
    assign wr_go = wport_i.we && !rst_i
                && (lvl_eff || edge_ev); // see RL19 see RL10 see RL18

    assign a5    = {wport_i.second_data_pin, wport_i.addr};
    assign mem32 = {fg_bits[`LUTR_FG_G], fg_bits[`LUTR_FG_F]};

    // ************************************************
    // routing to the two function generators
    // ************************************************

    always_comb begin
        fg_ra[`LUTR_FG_F] = wport_i.addr; // see RL5
        fg_ra[`LUTR_FG_G] = mode_dp ? secondary_read_addr_i
                                    : wport_i.addr; // see RL8
        if (mode_32) begin
            // fifth address bit steers the write to one half
            fg_we[`LUTR_FG_F] = wr_go && !wport_i.second_data_pin; // see RL21
            fg_we[`LUTR_FG_G] = wr_go && wport_i.second_data_pin;
            fg_wd[`LUTR_FG_F] = wport_i.first_data_pin;
            fg_wd[`LUTR_FG_G] = wport_i.first_data_pin;
        end else if (mode_dp) begin
            // both copies take every write at the shared address
            fg_we[`LUTR_FG_F] = wr_go; // see RL1 see RL7
            fg_we[`LUTR_FG_G] = wr_go;
            fg_wd[`LUTR_FG_F] = wport_i.first_data_pin;
            fg_wd[`LUTR_FG_G] = wport_i.first_data_pin;
        end else begin
            fg_we[`LUTR_FG_F] = wr_go; // see RL24
            fg_we[`LUTR_FG_G] = wr_go;
            fg_wd[`LUTR_FG_F] = wport_i.first_data_pin;
            fg_wd[`LUTR_FG_G] = wport_i.second_data_pin;
        end
    end

    genvar g;
    generate
        for (g = 0; g < `LUTR_FG_CNT; g = g + 1) begin : gen_fg
            lutr_fgen #(
                .INIT      (`LUTR_FGEN_INIT)
            ) u_fg (
                .clk_i     (clk_i),
                .ce_i      (ce_i),
                .we_i      (fg_we[g]),
                .wr_addr_i (wport_i.addr),
                .wr_data_i (fg_wd[g]),
                .rd_addr_i (fg_ra[g]),
                .rd_o      (fg_rd[g]),
                .bits_o    (fg_bits[g])
            );
        end
    endgenerate

    // ************************************************
    // read outputs
    // ************************************************

    // output flop samples the array before the write lands, so old data
    // shows first and new data one cycle later
    always_comb begin
        if (mode_32) begin
            prim_d = wport_i.second_data_pin ? fg_rd[`LUTR_FG_G]
                                             : fg_rd[`LUTR_FG_F]; // see RL23
            sec_d  = 1'b0;
        end else begin
            prim_d = fg_rd[`LUTR_FG_F]; // see RL6
            sec_d  = fg_rd[`LUTR_FG_G]; // see RL2 see RL3
        end
    end

    // ************************************************
    // bus and state update
    // ************************************************

    assign bus_req = wb_cyc_i && wb_stb_i && !s_q.ack;
    assign bus_wr  = bus_req && wb_we_i && wb_sel_i[0];

    // moving the address under a held level strobe is flagged
    assign glitch_set = lvl_eff && wport_i.we && s_q.we_prev
                     && (wport_i.addr != s_q.addr_prev); // see RL12 see RL11
    assign glitch_clr = bus_wr && (wb_adr_i == `LUTR_ADR_STAT)
                     && wb_dat_i[`LUTR_W1C_GLITCH];

    always_comb begin
        s_d             = s_q;
        s_d.wclk_prev   = wclk_i;
        s_d.we_prev     = wport_i.we;
        s_d.addr_prev   = wport_i.addr;
        s_d.stat.prim   = prim_d;
        s_d.stat.sec    = sec_d;
        // set wins over a clear in the same cycle
        s_d.stat.glitch = glitch_set || (s_q.stat.glitch && !glitch_clr);
        s_d.ack         = bus_req;
        if (bus_wr && (wb_adr_i == `LUTR_ADR_CTRL)) begin
            s_d.ctrl = lutr_ctrl_s'(wb_dat_i[`LUTR_CTRL_BITS]);
        end
        if (bus_req) begin
            unique case (wb_adr_i)
                `LUTR_ADR_CTRL: s_d.rdat = 32'(s_q.ctrl);
                `LUTR_ADR_STAT: s_d.rdat = 32'(s_q.stat);
                `LUTR_ADR_MEM:  s_d.rdat = mem32;
                default:        s_d.rdat = `LUTR_WB_ZERO;
            endcase
        end
    end

    // ce low freezes everything but reset, the bus included
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_q <= `LUTR_TOP_RST;
        end else if (ce_i) begin
            s_q <= s_d;
        end
    end

    assign wb_dat_o             = s_q.rdat;
    assign wb_ack_o             = s_q.ack;
    assign primary_read_out_o   = s_q.stat.prim;
    assign secondary_read_out_o = s_q.stat.sec;

    // ************************************************
    // checks
    // ************************************************

    a_dp_shared_write: assert property (@(posedge clk_i) disable iff (rst_i) // see RL7
        ce_i && mode_dp && wr_go
        |=> fg_bits[`LUTR_FG_F][$past(wport_i.addr)] == $past(wport_i.first_data_pin)
         && fg_bits[`LUTR_FG_G][$past(wport_i.addr)] == $past(wport_i.first_data_pin))
        else $error("dual-port write missed a copy");

    a_dp_second_read: assert property (@(posedge clk_i) disable iff (rst_i) // see RL8
        ce_i && mode_dp
        |=> secondary_read_out_o
            == $past(fg_bits[`LUTR_FG_G][secondary_read_addr_i]))
        else $error("secondary read shows wrong bit");

    a_primary_read: assert property (@(posedge clk_i) disable iff (rst_i) // see RL6
        ce_i && !mode_32
        |=> primary_read_out_o == $past(fg_bits[`LUTR_FG_F][wport_i.addr]))
        else $error("primary read shows wrong bit");

    a_read_old_new: assert property (@(posedge clk_i) disable iff (rst_i) // see RL23
        ce_i && mode_dp && wr_go && (secondary_read_addr_i == wport_i.addr)
        ##1 ce_i && (secondary_read_addr_i == $past(wport_i.addr))
        |=> secondary_read_out_o == $past(wport_i.first_data_pin, 2))
        else $error("new data not seen after write");

    a_level_write: assert property (@(posedge clk_i) disable iff (rst_i) // see RL10
        ce_i && lvl_eff && !mode_32 && wport_i.we
        |=> fg_bits[`LUTR_FG_F][$past(wport_i.addr)] == $past(wport_i.first_data_pin)
         && fg_bits[`LUTR_FG_G][$past(wport_i.addr)] == $past(wport_i.second_data_pin))
        else $error("level write not stored");

    a_dp_edge_only: assert property (@(posedge clk_i) disable iff (rst_i) // see RL4
        ce_i && mode_dp && !edge_ev
        |=> $stable(mem32))
        else $error("dual-port wrote without an edge");

    a_strobe_low: assert property (@(posedge clk_i) disable iff (rst_i) // see RL19
        ce_i && !wport_i.we
        |=> $stable(mem32))
        else $error("write with strobe low");

    a_reset_keeps: assert property (@(posedge clk_i) // see RL18
        rst_i
        |=> $stable(mem32))
        else $error("reset changed contents");

    a_wide_write: assert property (@(posedge clk_i) disable iff (rst_i) // see RL21
        ce_i && mode_32 && wr_go
        |=> mem32[$past(a5)] == $past(wport_i.first_data_pin))
        else $error("32x1 write went astray");

    a_fall_edge: assert property (@(posedge clk_i) disable iff (rst_i) // see RL20
        ce_i && s_q.ctrl.fall && !lvl_eff && wport_i.we
        && !s_q.wclk_prev && wclk_i
        |=> $stable(mem32))
        else $error("falling mode wrote on rise");

    a_glitch_flag: assert property (@(posedge clk_i) disable iff (rst_i) // see RL12
        ce_i && glitch_set
        |=> s_q.stat.glitch [*2] or (s_q.stat.glitch ##1 !ce_i))
        else $error("address glitch not flagged");

    a_bus_ack: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && bus_req
        |=> wb_ack_o ##1 (!wb_ack_o || !ce_i))
        else $error("ack timing wrong");

    // ************************************************
    // reset, enable, bus and mode checks
    // ************************************************

    // reset acts even while the enable is low
    a_reset_clears: assert property (@(posedge clk_i)
        rst_i
        |=> !wb_ack_o && wb_dat_o == `LUTR_WB_ZERO
         && !primary_read_out_o && !secondary_read_out_o)
        else $error("reset left an output set");

    // a frozen cycle must drop any write and leave the array and state as they were
    a_ce_freeze: assert property (@(posedge clk_i) disable iff (rst_i)
        !ce_i
        |=> $stable(mem32) && $stable(s_q))
        else $error("state moved with enable low");

    a_ack_idle: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && !(wb_cyc_i && wb_stb_i)
        |=> !wb_ack_o)
        else $error("ack without a request");

    a_ctrl_write: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && bus_wr && (wb_adr_i == `LUTR_ADR_CTRL)
        |=> s_q.ctrl == $past(wb_dat_i[`LUTR_CTRL_BITS]))
        else $error("control write not taken");

    a_glitch_clear: assert property (@(posedge clk_i) disable iff (rst_i) // see RL12
        ce_i && glitch_clr && !glitch_set
        |=> !s_q.stat.glitch)
        else $error("glitch flag not cleared");

    // fifth address bit picks the half that is read
    a_wide_read: assert property (@(posedge clk_i) disable iff (rst_i) // see RL21
        ce_i && mode_32
        |=> primary_read_out_o == $past(mem32[a5]))
        else $error("32x1 read shows wrong bit");

    a_wide_sec_low: assert property (@(posedge clk_i) disable iff (rst_i) // see RL21
        ce_i && mode_32
        |=> !secondary_read_out_o)
        else $error("secondary out active in 32x1");

    a_latch_follow: assert property (@(posedge clk_i) disable iff (rst_i) // see RL11
        ce_i && lvl_eff && !mode_32 && wport_i.we && s_q.we_prev
        && $changed(wport_i.first_data_pin)
        |=> fg_bits[`LUTR_FG_F][$past(wport_i.addr)] == $past(wport_i.first_data_pin))
        else $error("data change under strobe lost");

    a_dp_no_level: assert property (@(posedge clk_i) disable iff (rst_i) // see RL4
        ce_i && mode_dp && s_q.ctrl.lvl && !edge_ev
        |=> $stable(mem32))
        else $error("dual-port took a level write");

endmodule

// [rtl/lutr_cfg.svh]
// Functional notes
// RL1: dual-port mode joins both generators into one 16x1 array, two read ports.
// RL2: a write and a second-port read at different addresses share one cycle.
// RL3: a write and a read at the same address also share one cycle.
// RL4: dual-port writes are always edge-triggered; level mode is ignored there.
// RL5: shared address is read and write address of the first generator.
// RL6: primary read output shows the bit at the shared address.
// RL7: second generator writes at the shared address, keeping both copies equal.
// RL8: secondary read address selects the bit shown on the secondary output.
// RL9: user logic keeps the post-edge write-clock phase under 1 ms, never stopped.
// RL10: level mode writes data while the write strobe is high, no edge needed.
// RL11: level mode is a latch: data changes during strobe are written.
// RL12: address change during level strobe may write undefined data anywhere.
// RL13: user raises strobe after address settles, drops it before address moves.
// RL14: user keeps write data stable around the strobe falling edge.
// RL15: new designs should use edge mode; level mode is for compatibility.
// RL16: without explicit initial contents every location holds zero.
// RL17: initial contents load only at configuration, never later.
// RL18: global reset leaves the array contents untouched.
// RL19: active write-clock edge captures address, data, strobe; writes if strobe high.
// RL20: write edge selectable rising (default) or falling, for both generators.
// RL21: in 32x1 mode second data pin is address bit 4, first carries data.
// RL22: reads are combinational and alike in every mode. Here the read outputs come from a flop, one cycle behind the array.
// RL23: same-location read shows old value until the write edge, new after.
// RL24: in 16x2 mode each generator stores its own data pin's bit.
`ifndef LUTR_CFG_SVH
`define LUTR_CFG_SVH

`define LUTR_ADR_CTRL    4'h0
`define LUTR_ADR_STAT    4'h4
`define LUTR_ADR_MEM     4'h8
`define LUTR_MODE_SP16X2 2'h0
`define LUTR_MODE_SP32X1 2'h1
`define LUTR_MODE_DP16X1 2'h2
`define LUTR_TOP_RST     '0
`define LUTR_FGEN_INIT   16'h0000
`define LUTR_FG_F        0
`define LUTR_FG_G        1
`define LUTR_FG_CNT      2
`define LUTR_CTRL_BITS   3:0
`define LUTR_W1C_GLITCH  2
`define LUTR_WB_ZERO     32'h0000_0000

`endif

// [rtl/lutr_pkg.sv]
package lutr_pkg;

    typedef logic [1:0] lutr_mode_t;

    typedef struct packed {
        logic       lvl;
        logic       fall;
        lutr_mode_t mode;
    } lutr_ctrl_s;

    typedef struct packed {
        logic       we;
        logic [3:0] addr;
        logic       first_data_pin;
        logic       second_data_pin;
    } lutr_wport_s;

    typedef struct packed {
        logic glitch;
        logic sec;
        logic prim;
    } lutr_stat_s;

    typedef struct packed {
        lutr_ctrl_s  ctrl;
        logic        wclk_prev;
        logic        we_prev;
        logic [3:0]  addr_prev;
        logic        ack;
        logic [31:0] rdat;
        lutr_stat_s  stat;
    } lutr_top_s;

    typedef struct packed {
        logic [15:0] bits;
    } lutr_fgen_s;

endpackage

// [rtl/lutr_fgen.sv]
`timescale 1ns/1ps
`include "lutr_cfg.svh"

module lutr_fgen
    import lutr_pkg::*;
#(
    parameter logic [15:0] INIT = `LUTR_FGEN_INIT
) (
    input  wire logic        clk_i,
    input  wire logic        ce_i,
    input  wire logic        we_i,
    input  wire logic [3:0]  wr_addr_i,
    input  wire logic        wr_data_i,
    input  wire logic [3:0]  rd_addr_i,
    output logic             rd_o,
    output logic [15:0]      bits_o
);

    // contents load only at configuration; no reset reaches them
    lutr_fgen_s s_q = '{bits: INIT}; // see RL16
    lutr_fgen_s s_d;

    always_comb begin
        s_d = s_q;
        if (ce_i && we_i) begin
            s_d.bits[wr_addr_i] = wr_data_i;
        end
    end

    always_ff @(posedge clk_i) begin
        s_q <= s_d; // see RL17
    end

    // asynchronous read of the look-up table
    assign rd_o   = s_q.bits[rd_addr_i]; // see RL22
    assign bits_o = s_q.bits;

endmodule

// [bench/lutr_user_model.sv]
`timescale 1ns/1ps

module lutr_user_model
    import lutr_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        fall_i,
    input  wire logic        lvl_i,
    input  wire lutr_wport_s req_i,
    output logic             wclk_o,
    output lutr_wport_s      wport_o,
    output logic             load_o
);
    // write clock runs free, never parked after its active edge
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wclk_o  <= 1'b0;
            wport_o <= '0;
            load_o  <= 1'b0;
        end else begin
            wclk_o <= ~wclk_o;
            load_o <= (wclk_o == fall_i);
            if (wclk_o == fall_i || lvl_i) begin
                wport_o <= req_i;
            end else begin
                // strobe off, data toggled so a wrong-phase capture shows up
                wport_o <= '{1'b0, wport_o.addr, ~wport_o.first_data_pin,
                             ~wport_o.second_data_pin};
            end
        end
    end
endmodule

// [bench/tb_lutr_top.sv]
`timescale 1ns/1ps
`include "lutr_cfg.svh"

module tb_lutr_top
    import lutr_pkg::*;
;
    logic        clk_i, rst_i, ce_i, cyc, stb, wwe, ack, fall, lvl, prim, sec, wclk, load;
    logic [3:0]  adr, sra;
    logic [31:0] dat, rdat, rd, sh, seed, r;
    lutr_wport_s req, wport, w;
    lutr_mode_t  m;
    int          failures, checks_done, cycles;
    logic [3:0]  ctl_tab [7];

    lutr_top lutr_top_inst (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(wwe), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .wclk_i(wclk), .wport_i(wport),
        .secondary_read_addr_i(sra), .primary_read_out_o(prim), .secondary_read_out_o(sec));

    lutr_user_model lutr_user_model_inst (.clk_i(clk_i), .rst_i(rst_i), .fall_i(fall),
        .lvl_i(lvl), .req_i(req), .wclk_o(wclk), .wport_o(wport), .load_o(load));

    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end

    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            failures = failures + 1;
            $display("MISMATCH t=%0t timeout", $time);
            report_and_stop();
        end
    end

    // ****************
    // expectation
    // ****************
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    function automatic logic [31:0] upd(logic [31:0] s, lutr_mode_t md, lutr_wport_s x);
        if (!x.we) return s;
        if (md == 2'h1) begin
            s[{x.second_data_pin, x.addr}] = x.first_data_pin;
        end else if (md == 2'h2) begin
            s[x.addr]      = x.first_data_pin;
            s[16 + x.addr] = x.first_data_pin;
        end else begin
            s[x.addr]      = x.first_data_pin;
            s[16 + x.addr] = x.second_data_pin;
        end
        return s;
    endfunction

    // ****************
    // checks and bus
    // ****************
    task automatic chk1(input logic got, input logic exp, input string what);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH t=%0t %s got %b exp %b", $time, what, got, exp);
        end
    endtask

    task automatic chk32(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic wb(input logic we, input logic [3:0] a, input logic [31:0] d);
        cyc <= 1'b1;
        stb <= 1'b1;
        wwe <= we;
        adr <= a;
        dat <= d;
        do begin
            @(posedge clk_i);
        end while (ack !== 1'b1);
        rd = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic wr(input lutr_wport_s x, input logic [3:0] ra);
        logic [31:0] old;
        logic [4:0]  ix;
        old = sh;
        ix = (m == 2'h1) ? {x.second_data_pin, x.addr} : {1'b0, x.addr};
        req <= x;
        sra <= ra;
        do begin
            @(posedge clk_i);
        end while (!(load === 1'b1 && wport === x));
        sh = upd(sh, m, x);
        req.we <= 1'b0;
        @(posedge clk_i);
        if (!lvl) begin
            chk1(prim, old[ix], "prim old");
            if (m == 2'h2) chk1(sec, old[{1'b1, ra}], "sec old");
        end
        @(posedge clk_i);
        if (m != 2'h1) chk1(prim, sh[x.addr], "prim new");
        if (m == 2'h2) chk1(sec, sh[{1'b1, ra}], "sec new");
    endtask

    task report_and_stop;
        $display("checks_done=%0d failures=%0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // ****************
    // main sequence
    // ****************
    initial begin
        ctl_tab = '{4'h0, 4'h4, 4'h1, 4'h2, 4'h3, 4'hA, 4'h8};
        {cyc, stb, wwe, fall, lvl} = '0;
        {adr, sra, dat, req} = '0;
        {failures, checks_done, cycles} = '0;
        seed = 32'h98BFA502;
        sh = 32'h0000_0000;
        ce_i = 1'b1;
        rst_i = 1'b1;
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(1'b0, `LUTR_ADR_MEM, 32'h0);
        chk32(rd, 32'h0000_0000, "mem init");
        wb(1'b0, 4'hC, 32'h0);
        chk32(rd, 32'h0000_0000, "unmapped");
        for (int p = 0; p < 7; p++) begin
            wb(1'b1, `LUTR_ADR_CTRL, {28'h0, ctl_tab[p]});
            wb(1'b0, `LUTR_ADR_CTRL, 32'h0);
            chk32(rd, {28'h0, ctl_tab[p]}, "ctrl");
            m = ctl_tab[p][1:0];
            fall <= ctl_tab[p][2];
            lvl <= ctl_tab[p][3];
            for (int i = 0; i < 12; i++) begin
                r = xs();
                w = '{r[0] | (i < 2), r[4:1], r[5], r[6]};
                if (i < 2) w.addr = i[0] ? 4'hF : 4'h0;
                wr(w, (r[7] || i < 2) ? w.addr : r[11:8]);
            end
            if (ctl_tab[p] == 4'h8) begin
                // address and then data moved under a held level strobe
                r = xs();
                w = '{1'b1, r[3:0], r[4], r[5]};
                req <= w;
                sh = upd(sh, m, w);
                @(posedge clk_i);
                w.addr = ~w.addr;
                req.addr <= w.addr;
                @(posedge clk_i);
                w.first_data_pin = ~w.first_data_pin;
                req.first_data_pin <= w.first_data_pin;
                @(posedge clk_i);
                req.we <= 1'b0;
                sh = upd(sh, m, w);
                repeat (3) @(posedge clk_i);
                wb(1'b0, `LUTR_ADR_STAT, 32'h0);
                chk1(rd[`LUTR_W1C_GLITCH], 1'b1, "glitch set");
                wb(1'b1, `LUTR_ADR_STAT, 32'h0000_0004);
                wb(1'b0, `LUTR_ADR_STAT, 32'h0);
                chk1(rd[`LUTR_W1C_GLITCH], 1'b0, "glitch clear");
            end
            wb(1'b0, `LUTR_ADR_MEM, 32'h0);
            chk32(rd, sh, "mem");
        end
        // enable low must swallow a write that would change the array
        ce_i <= 1'b0;
        req <= '{1'b1, 4'h5, ~sh[5], ~sh[21]};
        repeat (3) @(posedge clk_i);
        req.we <= 1'b0;
        repeat (2) @(posedge clk_i);
        ce_i <= 1'b1;
        wb(1'b0, `LUTR_ADR_MEM, 32'h0);
        chk32(rd, sh, "ce frozen");
        rst_i <= 1'b1;
        fall <= 1'b0;
        lvl <= 1'b0;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(1'b0, `LUTR_ADR_MEM, 32'h0);
        chk32(rd, sh, "mem kept");
        wb(1'b0, `LUTR_ADR_CTRL, 32'h0);
        chk32(rd, 32'h0000_0000, "ctrl reset");
        report_and_stop();
    end
endmodule
